// *** src/pnpp_pkg.sv ***
// Purpose: shared constants for the parallel nvm programming port
// Assumes: core_clk at 125 MHz, pins sampled through two flip-flops
// Notes: times are kept in ns, cycle counts are derived below
//
// How it works
// RULE1: eeprom write: command 0x11, high addr, low addr, data, then page latch pulse.
// RULE2: programmer fills the page buffer byte by byte before starting the page write.
// RULE3: program strobe falling with byte-select-1 low writes the eeprom page; busy low.
// RULE4: programmer waits for ready before programming the next eeprom page.
// RULE5: flash read: command 0x02, then high and low address of one word.
// RULE6: flash read drives low byte with byte-select-1 low, high byte with it high.
// RULE7: data bus released once output enable goes high.
// RULE8: eeprom read: command 0x03 plus address; byte shown with output enable low.
// RULE9: fuse write: command 0x40, data byte, program strobe low, then wait ready.
// RULE10: fuse data bit 0 programs the fuse, bit 1 erases it.
// RULE11: high fuse targeted with byte-select-1 high and byte-select-2 low.
// RULE12: extended fuse targeted with byte-select-1 low and byte-select-2 high.
// RULE13: lock write: command 0x20, data byte, strobe; data bit 0 programs the lock.
// RULE14: with both main locks programmed, boot lock bits cannot be programmed.
// RULE15: lock bits return to erased only through chip erase; the code also reloads them erased (ERASED_BYTE) on rst_n.
// RULE16: fuse/lock read: command 0x04; programmed bits read as 0.
// RULE17: read selects (bs2,bs1): 00 low, 11 high, 10 extended fuses, 01 locks.
// RULE18: command 0x08 with low address 0..2 shows a signature byte, bs1 low.
// RULE19: command 0x08, low address 0, bs1 high shows the calibration byte.
// RULE20: busy goes low within 1 us of the program strobe falling.
// RULE21: writes keep busy low for 3.7 to 4.5 ms after the strobe fell.
// RULE22: chip erase keeps busy low for 7.5 to 9 ms after the strobe fell.
// RULE23: load strobe rise with action selects: 00 address, 01 data, 10 command, 11 idle.
// RULE24: last command and address are kept across accesses.
// RULE25: address load: byte-select-1 low picks low byte, high picks high byte.
// RULE26: data bus driven only with output enable low and a read command loaded.

package pnpp_pkg;

	// ****************************************
	// commands
	// ****************************************
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
	localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
	localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
	localparam logic [7:0] CMD_WRITE_EE = 8'h11;
	localparam logic [7:0] CMD_READ_SIG = 8'h08;
	localparam logic [7:0] CMD_READ_FUSE_LOCK = 8'h04;
	localparam logic [7:0] CMD_READ_FLASH = 8'h02;
	localparam logic [7:0] CMD_READ_EE = 8'h03;

	// ****************************************
	// pin codings
	// ****************************************
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD = 2'h2;
	// write select {bs2,bs1}
	localparam logic [1:0] WSEL_LOW = 2'h0;
	localparam logic [1:0] WSEL_HIGH = 2'h1;
	localparam logic [1:0] WSEL_EXT = 2'h2;
	// read select {bs2,bs1}
	localparam logic [1:0] RSEL_LOW = 2'h0;
	localparam logic [1:0] RSEL_LOCK = 2'h1;
	localparam logic [1:0] RSEL_EXT = 2'h2;
	localparam logic [1:0] RSEL_HIGH = 2'h3;

	// ****************************************
	// fields and values
	// ****************************************
	localparam int LOCK_MAIN_LSB = 0;
	localparam int LOCK_MAIN_W = 2;
	localparam int LOCK_BOOT_LSB = 2;
	localparam int LOCK_BOOT_W = 4;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] SIG_LAST_ADDR = 8'h02;
	localparam logic [7:0] CAL_ADDR = 8'h00;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_WR_MIN_NS = 3700000;
	localparam int T_WR_MAX_NS = 4500000;
	localparam int T_ERASE_MIN_NS = 7500000;
	localparam int T_ERASE_MAX_NS = 9000000;
	localparam int WR_MIN_CYC = (T_WR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_MAX_CYC = T_WR_MAX_NS / CLK_PERIOD_NS;
	localparam int ERASE_MIN_CYC = (T_ERASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_MAX_CYC = T_ERASE_MAX_NS / CLK_PERIOD_NS;
	// midpoint leaves margin for the pin synchroniser delay
	localparam int WR_BUSY_DEF_CYC = (WR_MIN_CYC + WR_MAX_CYC) / 2;
	localparam int ERASE_BUSY_DEF_CYC = (ERASE_MIN_CYC + ERASE_MAX_CYC) / 2;
	localparam int CNT_W = 21;

	typedef enum logic [1:0] {
		OP_IDLE,
		OP_PROG,
		OP_ERASE
	} pnpp_op_t;

endpackage

// *** src/pnpp_sync.sv ***
// Purpose: two flip-flop synchroniser for a group of pins
// Assumes: each bit is an independent level
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none

module pnpp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule
`default_nettype wire

// *** src/pnpp_port.sv ***
// Purpose: parallel programming port: loads, eeprom page write, reads, fuse and lock write
// Assumes: all pin inputs are asynchronous; data bus split into in/out/enable
// Notes: flash is readable and erased by chip erase; flash page programming is not built
`timescale 1ns/1ps
`default_nettype none

module pnpp_port
	import pnpp_pkg::*;
#(
	parameter int FLASH_WORDS = 8192,
	parameter int EE_BYTES = 512,
	parameter int EE_PAGE = 4,
	parameter int WR_BUSY_CYCLES = WR_BUSY_DEF_CYC,
	parameter int ERASE_BUSY_CYCLES = ERASE_BUSY_DEF_CYC,
	parameter logic [7:0] FUSE_LOW_INIT = 8'hff,
	parameter logic [7:0] FUSE_HIGH_INIT = 8'hff,
	parameter logic [7:0] FUSE_EXT_INIT = 8'hff,
	// identity bytes: values are arbitrary
	parameter logic [7:0] SIG_BYTE0 = 8'h5a,
	parameter logic [7:0] SIG_BYTE1 = 8'h3c,
	parameter logic [7:0] SIG_BYTE2 = 8'h0f,
	parameter logic [7:0] CAL_BYTE = 8'h80
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic load_strobe,
	input wire logic action_select_hi,
	input wire logic action_select_lo,
	input wire logic byte_select_one,
	input wire logic byte_select_two,
	input wire logic page_buffer_latch,
	input wire logic prog_strobe_n,
	input wire logic out_enable_n,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic ready_busy_flag,
	output logic [7:0] fuse_low,
	output logic [7:0] fuse_high,
	output logic [7:0] fuse_ext,
	output logic [7:0] lock_bits
);

	// ****************************************
	// sizes and checks
	// ****************************************
	localparam int FA_W = $clog2(FLASH_WORDS);
	localparam int EA_W = $clog2(EE_BYTES);
	localparam int PG_W = $clog2(EE_PAGE);
	localparam int SWP_N = (FLASH_WORDS > EE_BYTES) ? FLASH_WORDS : EE_BYTES;
	localparam int SWP_W = $clog2(SWP_N) + 1;
	localparam int PIN_W = 16;

	if (FLASH_WORDS < 2 || FLASH_WORDS > 65536 || (1 << FA_W) != FLASH_WORDS)
		$error("FLASH_WORDS must be a power of two up to 65536");
	if (EE_BYTES < 2 || EE_BYTES > 65536 || (1 << EA_W) != EE_BYTES)
		$error("EE_BYTES must be a power of two up to 65536");
	if (EE_PAGE < 2 || (1 << PG_W) != EE_PAGE || EE_PAGE > EE_BYTES || PG_W > 8)
		$error("EE_PAGE must be a power of two, 2..256, within EE_BYTES");
	if (WR_BUSY_CYCLES < 1 || WR_BUSY_CYCLES >= (1 << CNT_W))
		$error("WR_BUSY_CYCLES out of counter range");
	if (ERASE_BUSY_CYCLES <= SWP_N || ERASE_BUSY_CYCLES >= (1 << CNT_W))
		$error("ERASE_BUSY_CYCLES must exceed the erase sweep and fit the counter");

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic ls_q;
		logic pl_q;
		logic wr_q;
		logic [7:0] cmd;
		logic [7:0] addr_hi;
		logic [7:0] addr_lo;
		logic [7:0] data_lo;
		logic [EE_PAGE-1:0][7:0] pbuf;
		logic [EE_PAGE-1:0] pvalid;
		pnpp_op_t op;
		logic [CNT_W-1:0] cnt;
		logic [SWP_W-1:0] swp;
		logic [7:0] fuse_lo;
		logic [7:0] fuse_hi;
		logic [7:0] fuse_ex;
		logic [7:0] lock;
		logic [7:0] dout;
		logic doe;
		logic rdy;
	} pnpp_state_t;

	pnpp_state_t st_reg;
	pnpp_state_t st_next;

	logic [15:0] ee_mem [EE_BYTES];
	logic [15:0] flash_mem [FLASH_WORDS];

	// ****************************************
	// functions
	// ****************************************
	function automatic logic is_read_cmd(input logic [7:0] c);
		is_read_cmd = (c == CMD_READ_FLASH) || (c == CMD_READ_EE) || // RULE5
			(c == CMD_READ_FUSE_LOCK) || (c == CMD_READ_SIG);
	endfunction

	function automatic logic [7:0] lock_program(input logic [7:0] cur, input logic [7:0] req);
		logic [7:0] nxt;
		nxt = cur & req; // RULE13 RULE15
		if (cur[LOCK_MAIN_LSB +: LOCK_MAIN_W] == '0) begin
			nxt[LOCK_BOOT_LSB +: LOCK_BOOT_W] = cur[LOCK_BOOT_LSB +: LOCK_BOOT_W]; // RULE14
		end
		lock_program = nxt;
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [PIN_W-1:0] pins_s;
	logic s_ls;
	logic s_xa1;
	logic s_xa0;
	logic s_bs1;
	logic s_bs2;
	logic s_pl;
	logic s_wr_n;
	logic s_oe_n;
	logic [7:0] s_data;

	// program strobe and output enable idle high out of reset so no false falling edge
	pnpp_sync #(
		.W(PIN_W),
		.RST_VAL(16'h00c0)
	) u_pin_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in({data_in, out_enable_n, prog_strobe_n, page_buffer_latch, byte_select_two,
			byte_select_one, action_select_lo, action_select_hi, load_strobe}),
		.sync_out(pins_s)
	);

	assign s_ls = pins_s[0];
	assign s_xa1 = pins_s[1];
	assign s_xa0 = pins_s[2];
	assign s_bs1 = pins_s[3];
	assign s_bs2 = pins_s[4];
	assign s_pl = pins_s[5];
	assign s_wr_n = pins_s[6];
	assign s_oe_n = pins_s[7];
	assign s_data = pins_s[15:8];

	// ****************************************
	// addressing and memory reads
	// ****************************************
	logic [15:0] addr16;
	logic [FA_W-1:0] flash_addr;
	logic [EA_W-1:0] ee_addr;
	logic [EA_W-PG_W-1:0] ee_page;
	logic [15:0] flash_word;
	logic [7:0] ee_byte;
	logic ee_commit;
	logic erase_wr;

	assign addr16 = {st_reg.addr_hi, st_reg.addr_lo};
	assign flash_addr = addr16[FA_W-1:0];
	assign ee_addr = addr16[EA_W-1:0];
	assign ee_page = ee_addr[EA_W-1:PG_W];
	assign flash_word = flash_mem[flash_addr];
	assign ee_byte = ee_mem[ee_addr][7:0];
	assign erase_wr = (st_reg.op == OP_ERASE) && (st_reg.swp < SWP_W'(SWP_N));

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic ls_rise;
		logic pl_rise;
		logic wr_fall;
		logic go;
		logic erase;
		ls_rise = s_ls & ~st_reg.ls_q;
		pl_rise = s_pl & ~st_reg.pl_q;
		wr_fall = st_reg.wr_q & ~s_wr_n;
		go = 1'b0;
		erase = 1'b0;
		ee_commit = 1'b0;
		st_next = st_reg;
		st_next.ls_q = s_ls;
		st_next.pl_q = s_pl;
		st_next.wr_q = s_wr_n;

		// loads; command and address persist until reloaded
		if (ls_rise) begin
			case ({s_xa1, s_xa0}) // RULE23 RULE24
				ACT_ADDR: begin
					if (s_bs1) begin
						st_next.addr_hi = s_data; // RULE25
					end else begin
						st_next.addr_lo = s_data; // RULE25
					end
				end
				ACT_DATA: begin
					if (!s_bs1) begin
						st_next.data_lo = s_data;
					end
				end
				ACT_CMD: begin
					st_next.cmd = s_data;
					st_next.pvalid = '0;
				end
				default: begin
				end
			endcase
		end

		// busy countdown; a strobe while busy is ignored
		case (st_reg.op)
			OP_PROG, OP_ERASE: begin
				if (st_reg.swp != SWP_W'(SWP_N)) begin
					st_next.swp = st_reg.swp + SWP_W'(1);
				end
				if (st_reg.cnt == '0) begin
					st_next.op = OP_IDLE;
					st_next.rdy = 1'b1;
					// locks clear only after the arrays are gone
					if (st_reg.op == OP_ERASE) begin
						st_next.lock = ERASED_BYTE; // RULE15
					end
				end else begin
					st_next.cnt = st_reg.cnt - CNT_W'(1);
				end
			end
			default: begin
			end
		endcase

		if (wr_fall && st_reg.op == OP_IDLE) begin
			case (st_reg.cmd)
				CMD_WRITE_EE: begin
					if (!s_bs1) begin
						go = 1'b1; // RULE3
						ee_commit = 1'b1; // RULE3
						st_next.pvalid = '0;
					end
				end
				CMD_WRITE_FUSE: begin
					go = 1'b1; // RULE9
					case ({s_bs2, s_bs1})
						WSEL_LOW: st_next.fuse_lo = st_reg.data_lo; // RULE10
						WSEL_HIGH: st_next.fuse_hi = st_reg.data_lo; // RULE11
						WSEL_EXT: st_next.fuse_ex = st_reg.data_lo; // RULE12
						default: go = 1'b0;
					endcase
				end
				CMD_WRITE_LOCK: begin
					go = 1'b1;
					st_next.lock = lock_program(st_reg.lock, st_reg.data_lo); // RULE13
				end
				CMD_CHIP_ERASE: begin
					erase = 1'b1;
				end
				default: begin
				end
			endcase
			if (go) begin
				st_next.op = OP_PROG;
				st_next.rdy = 1'b0; // RULE3 RULE20
				st_next.cnt = CNT_W'(WR_BUSY_CYCLES - 1); // RULE21
				st_next.swp = SWP_W'(SWP_N);
			end else if (erase) begin
				st_next.op = OP_ERASE;
				st_next.rdy = 1'b0; // RULE20
				st_next.cnt = CNT_W'(ERASE_BUSY_CYCLES - 1); // RULE22
				st_next.swp = '0;
			end
		end

		// latch after the page commit so a same-cycle latch is kept
		if (pl_rise && st_reg.cmd == CMD_WRITE_EE) begin
			st_next.pbuf[st_reg.addr_lo[PG_W-1:0]] = st_reg.data_lo; // RULE1
			st_next.pvalid[st_reg.addr_lo[PG_W-1:0]] = 1'b1; // RULE1
		end

		// read path
		st_next.doe = !s_oe_n && is_read_cmd(st_reg.cmd); // RULE7 RULE26
		st_next.dout = '0;
		if (st_next.doe) begin
			case (st_reg.cmd)
				CMD_READ_FLASH: st_next.dout = s_bs1 ? flash_word[15:8] : flash_word[7:0]; // RULE6
				CMD_READ_EE: st_next.dout = ee_byte; // RULE8
				CMD_READ_FUSE_LOCK: begin
					case ({s_bs2, s_bs1}) // RULE16 RULE17
						RSEL_LOW: st_next.dout = st_reg.fuse_lo;
						RSEL_HIGH: st_next.dout = st_reg.fuse_hi;
						RSEL_EXT: st_next.dout = st_reg.fuse_ex;
						default: st_next.dout = st_reg.lock;
					endcase
				end
				default: begin
					if (s_bs1) begin
						st_next.dout = (st_reg.addr_lo == CAL_ADDR) ? CAL_BYTE : ERASED_BYTE; // RULE19
					end else if (st_reg.addr_lo <= SIG_LAST_ADDR) begin
						case (st_reg.addr_lo[1:0]) // RULE18
							2'h0: st_next.dout = SIG_BYTE0;
							2'h1: st_next.dout = SIG_BYTE1;
							default: st_next.dout = SIG_BYTE2;
						endcase
					end else begin
						st_next.dout = ERASED_BYTE;
					end
				end
			endcase
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.ls_q <= 1'b0;
			st_reg.wr_q <= 1'b1;
			st_reg.op <= OP_IDLE;
			st_reg.fuse_lo <= FUSE_LOW_INIT;
			st_reg.fuse_hi <= FUSE_HIGH_INIT;
			st_reg.fuse_ex <= FUSE_EXT_INIT;
			st_reg.lock <= ERASED_BYTE;
			st_reg.rdy <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// arrays have no reset: their content is nonvolatile by intent
	always_ff @(posedge core_clk) begin
		if (ee_commit) begin
			for (int i = 0; i < EE_PAGE; i++) begin
				if (st_reg.pvalid[i]) begin
					ee_mem[{ee_page, PG_W'(i)}] <= {8'h00, st_reg.pbuf[i]}; // RULE3
				end
			end
		end
		if (erase_wr) begin
			if (st_reg.swp < SWP_W'(FLASH_WORDS)) begin
				flash_mem[st_reg.swp[FA_W-1:0]] <= {ERASED_BYTE, ERASED_BYTE}; // RULE22
			end
			if (st_reg.swp < SWP_W'(EE_BYTES)) begin
				ee_mem[st_reg.swp[EA_W-1:0]] <= {8'h00, ERASED_BYTE}; // RULE22
			end
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign data_out = st_reg.dout;
	assign data_oe = st_reg.doe;
	assign ready_busy_flag = st_reg.rdy;
	assign fuse_low = st_reg.fuse_lo;
	assign fuse_high = st_reg.fuse_hi;
	assign fuse_ext = st_reg.fuse_ex;
	assign lock_bits = st_reg.lock;

endmodule
`default_nettype wire

// *** sim/pnpp_port_assertions.sv ***
// Purpose: timing and state checks on the programming port pins
// Assumes: pins pass two sync flops and one register
// Notes: busy lengths come in as parameters
`timescale 1ns/1ps
`default_nettype none
module pnpp_port_assertions #(
	parameter int WR_BUSY_CYCLES = 20,
	parameter int ERASE_BUSY_CYCLES = 84
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic prog_strobe_n,
	input wire logic out_enable_n,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire logic ready_busy_flag,
	input wire logic [7:0] fuse_low,
	input wire logic [7:0] lock_bits
);
	// ****
	// busy length counter
	// ****
	logic [20:0] busy_cnt_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt_reg <= '0;
		end else if (ready_busy_flag) begin
			busy_cnt_reg <= '0;
		end else begin
			busy_cnt_reg <= busy_cnt_reg + 21'h1;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ****
	// properties
	// ****
	property p_busy_len;
		$rose(ready_busy_flag) |->
			busy_cnt_reg == WR_BUSY_CYCLES || busy_cnt_reg == ERASE_BUSY_CYCLES;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy length wrong");
	property p_busy_cause;
		$fell(ready_busy_flag) |-> !$past(prog_strobe_n) && $past(prog_strobe_n, 5);
	endproperty
	a_busy_cause: assert property (p_busy_cause)
		else $error("busy without strobe fall");
	property p_oe_release;
		$rose(out_enable_n) |-> ##3 !data_oe;
	endproperty
	a_oe_release: assert property (p_oe_release)
		else $error("bus not released");
	property p_oe_needs_low;
		data_oe |-> !$past(out_enable_n, 3);
	endproperty
	a_oe_needs_low: assert property (p_oe_needs_low)
		else $error("bus driven without enable");
	property p_out_zero;
		!data_oe |-> data_out == 8'h00;
	endproperty
	a_out_zero: assert property (p_out_zero)
		else $error("data out while idle");
	property p_fuse_when_busy;
		!$stable(fuse_low) |-> !ready_busy_flag || !$past(ready_busy_flag);
	endproperty
	a_fuse_when_busy: assert property (p_fuse_when_busy)
		else $error("fuse changed outside write");
	property p_lock_no_set;
		(lock_bits & ~$past(lock_bits)) != 8'h00 |->
			!$past(ready_busy_flag) || !$past(ready_busy_flag, 2);
	endproperty
	a_lock_no_set: assert property (p_lock_no_set)
		else $error("lock bit erased outside erase");
	property p_boot_lock;
		$past(lock_bits[1:0]) == 2'h0 |-> ($past(lock_bits[5:2]) & ~lock_bits[5:2]) == 4'h0;
	endproperty
	a_boot_lock: assert property (p_boot_lock)
		else $error("boot lock programmed in mode 3");
endmodule
bind pnpp_port pnpp_port_assertions #(
	.WR_BUSY_CYCLES(WR_BUSY_CYCLES),
	.ERASE_BUSY_CYCLES(ERASE_BUSY_CYCLES)
) chk_u (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.prog_strobe_n(prog_strobe_n),
	.out_enable_n(out_enable_n),
	.data_out(data_out),
	.data_oe(data_oe),
	.ready_busy_flag(ready_busy_flag),
	.fuse_low(fuse_low),
	.lock_bits(lock_bits)
);
`default_nettype wire

// *** sim/pnpp_prog_model.sv ***
// Purpose: external programmer model driving the port pins
// Assumes: each level held 4 cycles, above the 3 the port needs
// Notes: a released bus shows the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module pnpp_prog_model (
	input wire logic core_clk,
	input wire logic ready_busy_flag,
	input wire logic data_oe,
	input wire logic [7:0] data_out,
	output logic load_strobe,
	output logic action_select_hi,
	output logic action_select_lo,
	output logic byte_select_one,
	output logic byte_select_two,
	output logic page_buffer_latch,
	output logic prog_strobe_n,
	output logic out_enable_n,
	output logic [7:0] data_in
);
	logic [7:0] drive_val;
	assign data_in = data_oe ? data_out : drive_val;
	initial begin
		{load_strobe, action_select_hi, action_select_lo} = 3'h0;
		{byte_select_one, byte_select_two, page_buffer_latch} = 3'h0;
		{prog_strobe_n, out_enable_n} = 2'h3;
		drive_val = 8'h00;
	end
	task automatic hold();
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	task automatic ld(input logic [1:0] act, input logic bs1, input logic [7:0] v);
		{action_select_hi, action_select_lo} = act;
		byte_select_one = bs1;
		drive_val = v;
		hold();
		load_strobe = 1'b1;
		hold();
		load_strobe = 1'b0;
		hold();
	endtask
	task automatic latch();
		page_buffer_latch = 1'b1;
		hold();
		page_buffer_latch = 1'b0;
		hold();
	endtask
	// bounded wait so a stuck busy cannot hang the run
	task automatic prog(input logic bs2, input logic bs1, output int n);
		{byte_select_two, byte_select_one} = {bs2, bs1};
		hold();
		prog_strobe_n = 1'b0;
		hold();
		prog_strobe_n = 1'b1;
		n = 0;
		while (!ready_busy_flag && n < 2000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		{byte_select_two, byte_select_one} = 2'h0;
	endtask
	task automatic rd(input logic bs2, input logic bs1, output logic [7:0] v);
		{byte_select_two, byte_select_one} = {bs2, bs1};
		drive_val = ~drive_val;
		out_enable_n = 1'b0;
		hold();
		v = data_in;
		out_enable_n = 1'b1;
		hold();
	endtask
endmodule
`default_nettype wire

// *** sim/test_parallel_nvm_programming_port.sv ***
// Purpose: self-checking bench for the parallel programming port
// Assumes: short busy counts and small memories
// Notes: chip erase runs first since memories are not reset
`timescale 1ns/1ps
`default_nettype none
module test_parallel_nvm_programming_port
	import pnpp_pkg::*;
;
	// arbitrary id values
	localparam logic [7:0] SIGS [3] = '{8'h1e, 8'h93, 8'h0b};
	localparam logic [7:0] CAL_VAL = 8'h6d;
	localparam int WR_TB = 20;
	localparam int ERASE_TB = 84;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic load_strobe, action_select_hi, action_select_lo, byte_select_one, byte_select_two;
	logic page_buffer_latch, prog_strobe_n, out_enable_n, data_oe, ready_busy_flag;
	logic [7:0] data_in, data_out, fuse_low, fuse_high, fuse_ext, lock_bits, rv;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	int n;
	always #4 core_clk = ~core_clk;
	pnpp_prog_model m_u (.core_clk, .ready_busy_flag, .data_oe, .data_out, .load_strobe,
		.action_select_hi, .action_select_lo, .byte_select_one, .byte_select_two,
		.page_buffer_latch, .prog_strobe_n, .out_enable_n, .data_in);
	pnpp_port #(.FLASH_WORDS(64), .EE_BYTES(32), .WR_BUSY_CYCLES(WR_TB), .ERASE_BUSY_CYCLES(ERASE_TB),
		.SIG_BYTE0(SIGS[0]), .SIG_BYTE1(SIGS[1]), .SIG_BYTE2(SIGS[2]), .CAL_BYTE(CAL_VAL)
	) dut_u (.core_clk, .rst_n, .load_strobe, .action_select_hi, .action_select_lo,
		.byte_select_one, .byte_select_two, .page_buffer_latch, .prog_strobe_n,
		.out_enable_n, .data_in, .data_out, .data_oe, .ready_busy_flag, .fuse_low,
		.fuse_high, .fuse_ext, .lock_bits);
	// ****
	// helpers
	// ****
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rchk(input string what, input logic b2, input logic b1, input logic [7:0] e);
		m_u.rd(b2, b1, rv);
		chk(what, rv, e);
		chk("bus_release", {7'h0, data_oe}, 8'h00);
	endtask
	task automatic pg(input logic b2, input logic b1);
		m_u.prog(b2, b1, n);
		chk("busy_seen", {7'h0, n > 0}, 8'h01);
		// busy starts 3 cycles into the 4-cycle strobe, so one busy cycle precedes the poll
		chk("busy_len", 8'(n), 8'(WR_TB - 1));
	endtask
	task automatic erase();
		m_u.ld(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
		m_u.prog(1'b0, 1'b0, n);
		chk("erase_busy_seen", {7'h0, n > 0}, 8'h01);
		chk("erase_len", 8'(n), 8'(ERASE_TB - 1));
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_flash();
		chk("ready_at_reset", {7'h0, ready_busy_flag}, 8'h01);
		erase();
		m_u.ld(ACT_CMD, 1'b0, CMD_READ_FLASH);
		m_u.ld(ACT_ADDR, 1'b1, 8'h00);
		m_u.ld(ACT_ADDR, 1'b0, 8'h05);
		rchk("flash_lo", 1'b0, 1'b0, 8'hff);
		rchk("flash_hi", 1'b0, 1'b1, 8'hff);
	endtask
	task automatic t_eeprom();
		m_u.ld(ACT_CMD, 1'b0, CMD_WRITE_EE);
		m_u.ld(ACT_ADDR, 1'b1, 8'h00);
		for (int i = 0; i < 2; i++) begin
			m_u.ld(ACT_ADDR, 1'b0, 8'(4 + i));
			m_u.ld(ACT_DATA, 1'b0, 8'ha5 ^ 8'(i));
			m_u.latch();
		end
		pg(1'b0, 1'b0);
		m_u.ld(ACT_CMD, 1'b0, CMD_READ_EE);
		for (int i = 0; i < 3; i++) begin
			m_u.ld(ACT_ADDR, 1'b0, 8'(4 + i));
			rchk("ee_byte", 1'b0, 1'b0, i == 2 ? 8'hff : 8'ha5 ^ 8'(i));
		end
	endtask
	task automatic t_fuse();
		m_u.ld(ACT_CMD, 1'b0, CMD_WRITE_FUSE);
		m_u.ld(ACT_DATA, 1'b0, 8'h00);
		pg(1'b0, 1'b0);
		m_u.ld(ACT_DATA, 1'b0, 8'he2);
		pg(1'b0, 1'b0);
		chk("fuse_low", fuse_low, 8'he2);
		m_u.ld(ACT_DATA, 1'b0, 8'hd9);
		pg(1'b0, 1'b1);
		m_u.ld(ACT_DATA, 1'b0, 8'hfe);
		pg(1'b1, 1'b0);
		chk("fuse_high", fuse_high, 8'hd9);
		chk("fuse_ext", fuse_ext, 8'hfe);
		m_u.rd(1'b0, 1'b0, rv);
		chk("no_drive", rv, m_u.drive_val);
		m_u.ld(ACT_CMD, 1'b0, CMD_READ_FUSE_LOCK);
		rchk("rd_low", 1'b0, 1'b0, 8'he2);
		rchk("rd_high", 1'b1, 1'b1, 8'hd9);
		rchk("rd_ext", 1'b1, 1'b0, 8'hfe);
	endtask
	task automatic t_lock();
		m_u.ld(ACT_CMD, 1'b0, CMD_WRITE_LOCK);
		m_u.ld(ACT_DATA, 1'b0, 8'hf3);
		pg(1'b0, 1'b0);
		chk("lock_boot", lock_bits, 8'hf3);
		m_u.ld(ACT_DATA, 1'b0, 8'hf0);
		pg(1'b0, 1'b0);
		m_u.ld(ACT_DATA, 1'b0, 8'hc0);
		pg(1'b0, 1'b0);
		chk("lock_mode3", lock_bits, 8'hf0);
		m_u.ld(ACT_DATA, 1'b0, 8'hff);
		pg(1'b0, 1'b0);
		chk("lock_no_clear", lock_bits, 8'hf0);
		m_u.ld(ACT_CMD, 1'b0, CMD_READ_FUSE_LOCK);
		rchk("rd_lock", 1'b0, 1'b1, 8'hf0);
		erase();
		chk("lock_erased", lock_bits, 8'hff);
	endtask
	task automatic t_sig();
		m_u.ld(ACT_CMD, 1'b0, CMD_READ_SIG);
		for (int a = 0; a < 3; a++) begin
			m_u.ld(ACT_ADDR, 1'b0, 8'(a));
			rchk("sig", 1'b0, 1'b0, SIGS[a]);
		end
		m_u.ld(ACT_ADDR, 1'b0, CAL_ADDR);
		rchk("cal", 1'b0, 1'b1, CAL_VAL);
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			close_out();
		end
	end
	initial begin
		repeat (20) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		t_flash();
		t_eeprom();
		t_fuse();
		t_lock();
		t_sig();
		close_out();
	end
endmodule
`default_nettype wire
